// ==== src/psw_consts.svh ====
`ifndef PSW_CONSTS_SVH
`define PSW_CONSTS_SVH

// clock and time base
`define PSW_CLK_PERIOD_NS   20
`define PSW_TENTH_S_NS      100000000
`define PSW_PSC_W           23

// register byte offsets
`define PSW_ADDR_ENABLE     8'h00
`define PSW_ADDR_METHOD     8'h04
`define PSW_ADDR_SLP_FREQ   8'h08
`define PSW_ADDR_SLP_DEV    8'h0c
`define PSW_ADDR_SLP_DELAY  8'h10
`define PSW_ADDR_BST_VAL    8'h14
`define PSW_ADDR_BST_TIME   8'h18
`define PSW_ADDR_WAKE_FREQ  8'h1c
`define PSW_ADDR_WAKE_DEV   8'h20
`define PSW_ADDR_WAKE_DELAY 8'h24
`define PSW_ADDR_STATUS     8'h28

// reset values (freq 0.01 Hz, percent 0.1 %, time 0.1 s)
`define PSW_RST_ENABLE      1'h0
`define PSW_RST_METHOD      2'h0
`define PSW_RST_SLP_FREQ    16'h01f4
`define PSW_RST_SLP_DEV     16'h0032
`define PSW_RST_SLP_DELAY   16'h0258
`define PSW_RST_BST_VAL     16'h0064
`define PSW_RST_BST_TIME    16'h0064
`define PSW_RST_WAKE_FREQ   16'h01f4
`define PSW_RST_WAKE_DEV    16'h0032
`define PSW_RST_WAKE_DELAY  16'h0032

// sleep method codes
`define PSW_METHOD_TERM     2'h0
`define PSW_METHOD_FREQ     2'h1
`define PSW_METHOD_DEV      2'h2

// boost scale: percent in tenths
`define PSW_BOOST_SCALE     33'sd1000
`define PSW_REF_MAX         16'hffff

`endif

// ==== src/psw_pkg.sv ====
`include "psw_consts.svh"

package psw_pkg;

  // controller states, gray along run-qual-boost-sleep-wqual
  typedef enum logic [2:0] {
    PSW_RUN   = 3'h0,
    PSW_QUAL  = 3'h1,
    PSW_BOOST = 3'h3,
    PSW_SLEEP = 3'h2,
    PSW_WQUAL = 3'h6
  } psw_mode_t;

  // software settings
  typedef struct packed {
    logic        hvac_function_enable;
    logic [1:0]  sleep_method_select;
    logic [15:0] sleep_start_frequency;
    logic [15:0] sleep_start_deviation;
    logic [15:0] sleep_qualify_delay;
    logic [15:0] reference_boost_value;
    logic [15:0] reference_boost_time;
    logic [15:0] wake_start_frequency;
    logic [15:0] wake_deviation_threshold;
    logic [15:0] wake_qualify_delay;
  } psw_cfg_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr;
    logic        rd;
  } psw_bus_t;

  // drive-side process values
  typedef struct packed {
    logic [15:0] run_freq;
    logic [15:0] pid_ref;
    logic [15:0] pid_fb;
    logic        pid_negative;
    logic        at_upper_limit;
    logic        closed_loop;
  } psw_proc_t;

  // tick generator state
  typedef struct packed {
    logic [`PSW_PSC_W-1:0] cnt;
    logic                  tick;
  } psw_tick_st_t;

  // delay timer state
  typedef struct packed {
    logic [15:0] cnt;
  } psw_tmr_st_t;

  // controller state
  typedef struct packed {
    psw_cfg_t    cfg;
    psw_mode_t   mode;
    logic        term_s1;
    logic        term_s2;
    logic [31:0] rd_data;
    logic        sleep;
    logic        boost;
    logic        wake_load;
    logic        pid_preset;
    logic        forced;
    logic [15:0] ref_out;
  } psw_ctl_t;

endpackage

// ==== src/psw_tick_gen.sv ====
`timescale 1ns/1ps
`include "psw_consts.svh"

// one-cycle pulse every tenth of a second
module psw_tick_gen #(
  parameter int TICK_CYCLES = `PSW_TENTH_S_NS / `PSW_CLK_PERIOD_NS
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  psw_pkg::psw_tick_st_t r;       // registered state
  psw_pkg::psw_tick_st_t next_r;  // next state

  // count down period, pulse at wrap
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == '0) begin
      next_r.cnt  = `PSW_PSC_W'(TICK_CYCLES - 1);
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt - `PSW_PSC_W'(1);
    end
  end

  // register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_tick = r.tick;

endmodule

// ==== src/psw_delay_timer.sv ====
`timescale 1ns/1ps
`include "psw_consts.svh"

// counts tenth-second ticks, done when limit reached
module psw_delay_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tick,
  input  wire logic        i_restart,
  input  wire logic [15:0] i_limit,
  output logic             o_done
);

  psw_pkg::psw_tmr_st_t r;       // elapsed tenths
  psw_pkg::psw_tmr_st_t next_r;  // next elapsed

  // restart clears, ticks count up, saturates at limit
  always_comb begin
    next_r = r;
    if (i_restart) begin
      next_r.cnt = '0;
    end else if (i_tick && (r.cnt < i_limit)) begin
      next_r.cnt = r.cnt + 16'h0001;
    end
  end

  // register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // zero limit is done at once
  assign o_done = (r.cnt >= i_limit);

endmodule

// ==== src/psw_sleep_wake.sv ====
`timescale 1ns/1ps
`include "psw_consts.svh"

// sleep and wake-up sequencer for a pump drive
module psw_sleep_wake #(
  parameter int TICK_CYCLES = `PSW_TENTH_S_NS / `PSW_CLK_PERIOD_NS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rd_data,
  // drive process values, same clock
  input  wire logic [15:0] i_run_freq,
  input  wire logic [15:0] i_pid_ref,
  input  wire logic [15:0] i_pid_fb,
  input  wire logic        i_pid_negative,
  input  wire logic        i_at_upper_limit,
  input  wire logic        i_closed_loop,
  // terminal sleep command pin
  input  wire logic        i_term_sleep,
  // results to drive
  output logic [15:0]      o_ref_out,
  output logic             o_boost_active,
  output logic             o_sleep_active,
  output logic             o_wake_load,
  output logic [15:0]      o_wake_freq,
  output logic             o_pid_preset,
  output logic [2:0]       o_state
);

  psw_pkg::psw_bus_t  bus;       // grouped register request
  psw_pkg::psw_proc_t proc;      // grouped process values
  psw_pkg::psw_ctl_t  r;         // registered state
  psw_pkg::psw_ctl_t  next_r;    // next state

  logic               tick;      // tenth-second pulse
  logic               tmr_done;  // active delay elapsed
  logic               tmr_restart; // restart active delay
  logic [15:0]        tmr_limit; // active delay in tenths

  logic [15:0]        fb_above;  // feedback minus reference, floor 0
  logic [15:0]        fb_below;  // reference minus feedback, floor 0
  logic               slp_freq_ok; // frequency sleep condition
  logic               slp_dev_ok;  // deviation sleep condition
  logic               slp_cond;    // selected sleep condition
  logic               wake_cond;   // wake condition
  logic               misses_boost; // feedback short of boosted reference

  logic signed [32:0] boost_prod; // reference times boost
  logic signed [32:0] boost_adj;  // scaled boost amount
  logic signed [33:0] boost_sum;  // boosted reference, unclamped
  logic [15:0]        boost_ref;  // boosted reference, clamped

  // group ports into carriers
  assign bus  = '{addr: i_addr, wr_data: i_wr_data, wr: i_wr, rd: i_rd};
  assign proc = '{run_freq: i_run_freq, pid_ref: i_pid_ref, pid_fb: i_pid_fb,
                  pid_negative: i_pid_negative, at_upper_limit: i_at_upper_limit,
                  closed_loop: i_closed_loop};

  // tenth-second time base
  psw_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  // one shared delay timer, restarted on every state change
  psw_delay_timer u_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick),
    .i_restart (tmr_restart),
    .i_limit   (tmr_limit),
    .o_done    (tmr_done)
  );

  // delay chosen by current state
  always_comb begin
    case (r.mode)
      psw_pkg::PSW_QUAL:  tmr_limit = r.cfg.sleep_qualify_delay;
      psw_pkg::PSW_BOOST: tmr_limit = r.cfg.reference_boost_time;
      psw_pkg::PSW_WQUAL: tmr_limit = r.cfg.wake_qualify_delay;
      default:            tmr_limit = 16'h0000;
    endcase
  end

  // deviations between feedback and reference
  always_comb begin
    fb_above = (proc.pid_fb > proc.pid_ref) ? (proc.pid_fb - proc.pid_ref) : 16'h0000;
    fb_below = (proc.pid_ref > proc.pid_fb) ? (proc.pid_ref - proc.pid_fb) : 16'h0000;
  end

  // sleep and wake conditions
  always_comb begin
    slp_freq_ok = (proc.run_freq <= r.cfg.sleep_start_frequency);
    if (!proc.pid_negative) begin
      slp_dev_ok = (fb_above > r.cfg.sleep_start_deviation);
      wake_cond  = (fb_below > r.cfg.wake_deviation_threshold);
    end else begin
      slp_dev_ok = (fb_below > r.cfg.sleep_start_deviation);
      wake_cond  = (fb_above > r.cfg.wake_deviation_threshold);
    end
    case (r.cfg.sleep_method_select)
      `PSW_METHOD_FREQ: slp_cond = slp_freq_ok;
      `PSW_METHOD_DEV:  slp_cond = slp_dev_ok;
      default:          slp_cond = 1'b0;
    endcase
  end

  // boosted reference: ref + ref * boost / 1000, clamped
  always_comb begin
    boost_prod = 33'(signed'({1'b0, proc.pid_ref}) *
                     signed'(r.cfg.reference_boost_value));
    boost_adj  = boost_prod / `PSW_BOOST_SCALE;
    boost_sum  = 34'(signed'({1'b0, proc.pid_ref})) + 34'(boost_adj);
    if (boost_sum < 0) begin
      boost_ref = 16'h0000;
    end else if (boost_sum > 34'(signed'({1'b0, `PSW_REF_MAX}))) begin
      boost_ref = `PSW_REF_MAX;
    end else begin
      boost_ref = boost_sum[15:0];
    end
  end

  // feedback still short of the boosted reference
  always_comb begin
    if (!proc.pid_negative) begin
      misses_boost = (proc.pid_fb < r.ref_out);
    end else begin
      misses_boost = (proc.pid_fb > r.ref_out);
    end
  end

  // next-state logic: registers, pin sync, sequencer, outputs
  always_comb begin
    next_r            = r;
    next_r.wake_load  = 1'b0;
    next_r.pid_preset = 1'b0;

    // terminal pin synchroniser
    next_r.term_s1 = i_term_sleep;
    next_r.term_s2 = r.term_s1;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        `PSW_ADDR_ENABLE:     next_r.cfg.hvac_function_enable     = bus.wr_data[0];
        `PSW_ADDR_METHOD:     next_r.cfg.sleep_method_select      = bus.wr_data[1:0];
        `PSW_ADDR_SLP_FREQ:   next_r.cfg.sleep_start_frequency    = bus.wr_data[15:0];
        `PSW_ADDR_SLP_DEV:    next_r.cfg.sleep_start_deviation    = bus.wr_data[15:0];
        `PSW_ADDR_SLP_DELAY:  next_r.cfg.sleep_qualify_delay      = bus.wr_data[15:0];
        `PSW_ADDR_BST_VAL:    next_r.cfg.reference_boost_value    = bus.wr_data[15:0];
        `PSW_ADDR_BST_TIME:   next_r.cfg.reference_boost_time     = bus.wr_data[15:0];
        `PSW_ADDR_WAKE_FREQ:  next_r.cfg.wake_start_frequency     = bus.wr_data[15:0];
        `PSW_ADDR_WAKE_DEV:   next_r.cfg.wake_deviation_threshold = bus.wr_data[15:0];
        `PSW_ADDR_WAKE_DELAY: next_r.cfg.wake_qualify_delay       = bus.wr_data[15:0];
        default:              next_r.cfg = r.cfg;
      endcase
    end

    // register reads, data in the following cycle
    next_r.rd_data = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `PSW_ADDR_ENABLE:     next_r.rd_data = {31'h0, r.cfg.hvac_function_enable};
        `PSW_ADDR_METHOD:     next_r.rd_data = {30'h0, r.cfg.sleep_method_select};
        `PSW_ADDR_SLP_FREQ:   next_r.rd_data = {16'h0, r.cfg.sleep_start_frequency};
        `PSW_ADDR_SLP_DEV:    next_r.rd_data = {16'h0, r.cfg.sleep_start_deviation};
        `PSW_ADDR_SLP_DELAY:  next_r.rd_data = {16'h0, r.cfg.sleep_qualify_delay};
        `PSW_ADDR_BST_VAL:    next_r.rd_data = {16'h0, r.cfg.reference_boost_value};
        `PSW_ADDR_BST_TIME:   next_r.rd_data = {16'h0, r.cfg.reference_boost_time};
        `PSW_ADDR_WAKE_FREQ:  next_r.rd_data = {16'h0, r.cfg.wake_start_frequency};
        `PSW_ADDR_WAKE_DEV:   next_r.rd_data = {16'h0, r.cfg.wake_deviation_threshold};
        `PSW_ADDR_WAKE_DELAY: next_r.rd_data = {16'h0, r.cfg.wake_qualify_delay};
        `PSW_ADDR_STATUS:     next_r.rd_data = {26'h0, r.forced, r.boost, r.sleep,
                                                r.mode};
        default:              next_r.rd_data = 32'h0000_0000;  // unmapped reads zero
      endcase
    end

    // sequencer
    if (!r.cfg.hvac_function_enable) begin
      // function off: plain running, no sleep or wake
      next_r.mode = psw_pkg::PSW_RUN;
    end else if (r.cfg.sleep_method_select == `PSW_METHOD_TERM) begin
      // terminal method: pin level commands sleep directly
      if (r.term_s2) begin
        next_r.mode = psw_pkg::PSW_SLEEP;
      end else begin
        next_r.mode = psw_pkg::PSW_RUN;
        if (r.sleep) begin  // pulse only when leaving a stopped drive
          next_r.wake_load  = 1'b1;
          next_r.pid_preset = proc.closed_loop;
        end
      end
    end else begin
      case (r.mode)
        psw_pkg::PSW_RUN: begin
          // start qualifying when sleep condition appears
          if (slp_cond) begin
            next_r.mode = psw_pkg::PSW_QUAL;
          end
        end
        psw_pkg::PSW_QUAL: begin
          // lapse goes back to running, hold time moves to boost
          if (!slp_cond) begin
            next_r.mode = psw_pkg::PSW_RUN;
          end else if (tmr_done) begin
            next_r.mode = psw_pkg::PSW_BOOST;
          end
        end
        psw_pkg::PSW_BOOST: begin
          // note saturation case, sleep at end of boost time
          if (proc.at_upper_limit && misses_boost) begin
            next_r.forced = 1'b1;
          end
          if (tmr_done) begin
            next_r.mode = psw_pkg::PSW_SLEEP;
          end
        end
        psw_pkg::PSW_SLEEP: begin
          // wait for wake condition
          if (wake_cond) begin
            next_r.mode = psw_pkg::PSW_WQUAL;
          end
        end
        psw_pkg::PSW_WQUAL: begin
          // lapse returns to sleep, hold time wakes
          if (!wake_cond) begin
            next_r.mode = psw_pkg::PSW_SLEEP;
          end else if (tmr_done) begin
            next_r.mode       = psw_pkg::PSW_RUN;
            next_r.wake_load  = 1'b1;
            next_r.pid_preset = proc.closed_loop;
          end
        end
        default: begin
          next_r.mode = psw_pkg::PSW_RUN;
        end
      endcase
    end

    // forced flag stands from its boost until the drive runs again
    if (next_r.mode == psw_pkg::PSW_RUN || next_r.mode == psw_pkg::PSW_QUAL) begin
      next_r.forced = 1'b0;
    end

    // output levels follow the next state
    next_r.boost = (next_r.mode == psw_pkg::PSW_BOOST);
    next_r.sleep = (next_r.mode == psw_pkg::PSW_SLEEP) ||
                   (next_r.mode == psw_pkg::PSW_WQUAL);
    next_r.ref_out = next_r.boost ? boost_ref : proc.pid_ref;
  end

  // any state change restarts the shared delay
  assign tmr_restart = (next_r.mode != r.mode);

  // register everything, synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r                              <= '0;
      r.mode                         <= psw_pkg::PSW_RUN;
      r.cfg.hvac_function_enable     <= `PSW_RST_ENABLE;
      r.cfg.sleep_method_select      <= `PSW_RST_METHOD;
      r.cfg.sleep_start_frequency    <= `PSW_RST_SLP_FREQ;
      r.cfg.sleep_start_deviation    <= `PSW_RST_SLP_DEV;
      r.cfg.sleep_qualify_delay      <= `PSW_RST_SLP_DELAY;
      r.cfg.reference_boost_value    <= `PSW_RST_BST_VAL;
      r.cfg.reference_boost_time     <= `PSW_RST_BST_TIME;
      r.cfg.wake_start_frequency     <= `PSW_RST_WAKE_FREQ;
      r.cfg.wake_deviation_threshold <= `PSW_RST_WAKE_DEV;
      r.cfg.wake_qualify_delay       <= `PSW_RST_WAKE_DELAY;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign o_rd_data      = r.rd_data;
  assign o_ref_out      = r.ref_out;
  assign o_boost_active = r.boost;
  assign o_sleep_active = r.sleep;
  assign o_wake_load    = r.wake_load;
  assign o_wake_freq    = r.cfg.wake_start_frequency;
  assign o_pid_preset   = r.pid_preset;
  assign o_state        = r.mode;

endmodule

// ==== sim/psw_sleep_wake_checker.sv ====
`timescale 1ns/1ps
`include "psw_consts.svh"

// port-level watch on the sleep and wake sequencer
module psw_sleep_wake_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rd_data,
  input wire logic [15:0] i_run_freq,
  input wire logic [15:0] i_pid_ref,
  input wire logic [15:0] i_pid_fb,
  input wire logic        i_pid_negative,
  input wire logic        i_at_upper_limit,
  input wire logic        i_closed_loop,
  input wire logic        i_term_sleep,
  input wire logic [15:0] o_ref_out,
  input wire logic        o_boost_active,
  input wire logic        o_sleep_active,
  input wire logic        o_wake_load,
  input wire logic [15:0] o_wake_freq,
  input wire logic        o_pid_preset,
  input wire logic [2:0]  o_state
);
  logic        en_q; // mirrored enable
  logic [15:0] sd_q; // mirrored sleep delay
  logic [15:0] bt_q; // mirrored boost time
  logic [15:0] wd_q; // mirrored wake delay
  logic [2:0]  st_q; // state one clock ago
  logic [31:0] cnt;  // clocks spent in st_q
  logic        live; // past first edge after reset

  // fits a delay of d ticks, from two clocks early to one tick plus two clocks late
  function automatic logic span_ok(input logic [31:0] n, input logic [15:0] d);
    logic [31:0] lo;
    lo = {16'h0, d} * 32'(TICK_CYCLES);
    span_ok = (n + 32'h2 >= lo) && (n <= lo + 32'(TICK_CYCLES) + 32'h2);
  endfunction

  // legal moves: run-qual-boost-sleep-wqual, wqual-sleep, run-sleep, any to run
  function automatic logic step_ok(input logic [2:0] f, input logic [2:0] t);
    case ({f, t})
      6'h01, 6'h02, 6'h0b, 6'h1a, 6'h16, 6'h32: step_ok = 1'b1;
      default: step_ok = (t == 3'h0);
    endcase
  endfunction

  // mirror settings and time each state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      en_q <= `PSW_RST_ENABLE;
      sd_q <= `PSW_RST_SLP_DELAY;
      bt_q <= `PSW_RST_BST_TIME;
      wd_q <= `PSW_RST_WAKE_DELAY;
      st_q <= 3'h0;
      cnt  <= 32'h0;
      live <= 1'b0;
    end else begin
      live <= 1'b1;
      st_q <= o_state;
      cnt  <= (o_state != st_q) ? 32'h1 : cnt + 32'h1;
      if (i_wr && i_addr == `PSW_ADDR_ENABLE) en_q <= i_wr_data[0];
      if (i_wr && i_addr == `PSW_ADDR_SLP_DELAY) sd_q <= i_wr_data[15:0];
      if (i_wr && i_addr == `PSW_ADDR_BST_TIME) bt_q <= i_wr_data[15:0];
      if (i_wr && i_addr == `PSW_ADDR_WAKE_DELAY) wd_q <= i_wr_data[15:0];
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_disable_idle: assert property (
    !en_q |=> o_state == 3'h0 && !o_sleep_active) else $error("active while disabled");
  a_state_order: assert property (
    o_state != st_q |-> step_ok(st_q, o_state)) else $error("illegal state move");
  a_sleep_hold: assert property (
    st_q == 3'h1 && o_state == 3'h3 |-> span_ok(cnt, sd_q)) else $error("sleep delay off");
  a_boost_hold: assert property (
    st_q == 3'h3 && o_state == 3'h2 |-> span_ok(cnt, bt_q)) else $error("boost time off");
  a_wake_hold: assert property (
    en_q && st_q == 3'h6 && o_state == 3'h0 |-> span_ok(cnt, wd_q))
    else $error("wake delay off");
  a_boost_flag: assert property (
    o_boost_active == (o_state == 3'h3)) else $error("boost flag wrong");
  a_sleep_flag: assert property (
    o_sleep_active == (o_state == 3'h2 || o_state == 3'h6)) else $error("sleep flag wrong");
  a_wake_pulse: assert property (
    o_wake_load |-> o_state == 3'h0 && (st_q == 3'h2 || st_q == 3'h6) ##1 !o_wake_load)
    else $error("wake pulse wrong");
  a_preset_pair: assert property (
    o_pid_preset == (o_wake_load && $past(i_closed_loop))) else $error("preset wrong");
  a_ref_pass: assert property (
    live && !o_boost_active && !$past(o_boost_active) |-> o_ref_out == $past(i_pid_ref))
    else $error("reference not passed");
  a_read_idle: assert property (
    live && !$past(i_rd) |-> o_rd_data == 32'h0) else $error("read data not idle");

  c_boost: cover property (st_q == 3'h1 && o_state == 3'h3);
  c_sleep: cover property (st_q == 3'h3 && o_state == 3'h2);
  c_wake: cover property (o_wake_load && o_pid_preset);
endmodule

bind psw_sleep_wake psw_sleep_wake_checker #(.TICK_CYCLES(TICK_CYCLES))
  psw_sleep_wake_checker_i (.*);

// ==== sim/psw_drive_model.sv ====
`timescale 1ns/1ps

// drive frequency path: ramps, stops asleep, jumps on wake
module psw_drive_model #(
  parameter logic [15:0] UPPER = 16'h1388, // upper limit frequency
  parameter logic [15:0] STEP  = 16'h0040  // ramp per clock
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_target,
  input  wire logic        i_sleep,
  input  wire logic        i_wake_load,
  input  wire logic [15:0] i_wake_freq,
  output logic [15:0]      o_run_freq,
  output logic             o_at_upper
);
  // upper limit flag from present frequency
  assign o_at_upper = (o_run_freq >= UPPER);

  // frequency register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_run_freq <= 16'h0;
    end else if (i_wake_load) begin
      o_run_freq <= i_wake_freq;
    end else if (i_sleep) begin
      o_run_freq <= 16'h0;
    end else if (o_run_freq < i_target) begin
      o_run_freq <= (i_target - o_run_freq > STEP) ? o_run_freq + STEP : i_target;
    end else begin
      o_run_freq <= (o_run_freq - i_target > STEP) ? o_run_freq - STEP : i_target;
    end
  end
endmodule

// ==== sim/psw_sleep_wake_bench.sv ====
`timescale 1ns/1ps

// self-checking bench for the sleep sequencer
module psw_sleep_wake_bench;
  localparam logic [15:0] REF = 16'h03e8; // reference in use

  logic        sys_clk;     // 50 MHz
  logic        rst_n;       // sync reset
  logic [7:0]  addr;        // register address
  logic [31:0] wdata;       // write data
  logic        wr_en;       // write strobe
  logic        rd_en;       // read strobe
  logic [31:0] rd_data;     // read data
  logic [15:0] run_freq;    // drive frequency
  logic [15:0] target;      // drive goal
  logic [15:0] pid_ref;     // pid reference
  logic [15:0] pid_fb;      // pid feedback
  logic        pid_neg;     // negative action
  logic        at_upper;    // at upper limit
  logic        closed_loop; // closed-loop pid
  logic        term;        // terminal pin
  logic [15:0] ref_out;     // reference out
  logic        boost_on;    // boost flag
  logic        sleep_on;    // sleep flag
  logic        wake_load;   // wake pulse
  logic [15:0] wake_freq;   // wake frequency
  logic        pid_preset;  // preset pulse
  logic [2:0]  state;       // state
  int          errors = 0;
  int          check_count = 0;

  psw_sleep_wake #(.TICK_CYCLES(4)) psw_sleep_wake_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr_en), .i_rd(rd_en), .o_rd_data(rd_data), .i_run_freq(run_freq),
    .i_pid_ref(pid_ref), .i_pid_fb(pid_fb), .i_pid_negative(pid_neg),
    .i_at_upper_limit(at_upper), .i_closed_loop(closed_loop), .i_term_sleep(term),
    .o_ref_out(ref_out), .o_boost_active(boost_on), .o_sleep_active(sleep_on),
    .o_wake_load(wake_load), .o_wake_freq(wake_freq), .o_pid_preset(pid_preset),
    .o_state(state));

  psw_drive_model psw_drive_model_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_target(target), .i_sleep(sleep_on),
    .i_wake_load(wake_load), .i_wake_freq(wake_freq), .o_run_freq(run_freq),
    .o_at_upper(at_upper));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write, then a gap clock
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one read, data judged in the following cycle
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    check(rd_data, e);
    @(posedge sys_clk);
  endtask

  // bounded wait for a state
  task automatic wait_for(input logic [2:0] s, input int n);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (state !== s && k < n);
    check(32'(state), 32'(s));
    @(posedge sys_clk);
  endtask

  // bounded wait for the wake jump
  task automatic wait_wake(input logic pre);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (wake_load !== 1'b1 && k < 200);
    check(32'(wake_load), 32'h1);
    check(32'(wake_freq), 32'h1f4);
    check(32'(pid_preset), 32'(pre));
    @(negedge sys_clk);
    check(32'(run_freq), 32'h1f4);
    @(posedge sys_clk);
  endtask

  // default settings, then shortened delays
  task automatic t_defaults;
    logic [7:0]  a [12];
    logic [31:0] e [12];
    a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    e = '{32'h0, 32'h0, 32'h1f4, 32'h32, 32'h258, 32'h64, 32'h64, 32'h1f4, 32'h32,
          32'h32, 32'h0, 32'h0};
    for (int i = 0; i < 12; i++) begin
      rdchk(a[i], e[i]);
    end
    wr(8'h10, 32'h3);
    wr(8'h18, 32'h2);
    wr(8'h24, 32'h2);
    rdchk(8'h10, 32'h3);
    wr(8'h04, 32'h1);
    repeat (40) @(posedge sys_clk);
    check(32'(state), 32'h0);
  endtask

  // frequency sleep, lapse, boost, deviation wake
  task automatic t_freq;
    target <= 16'h01f5;
    repeat (20) @(posedge sys_clk);
    wr(8'h00, 32'h1);
    repeat (40) @(posedge sys_clk);
    check(32'(state), 32'h0);
    target <= 16'h01f4;
    wait_for(3'h1, 10);
    target <= 16'h01f5;
    wait_for(3'h0, 6);
    target <= 16'h01f4;
    wait_for(3'h3, 40);
    @(negedge sys_clk);
    check(32'(ref_out), 32'h44c);
    wait_for(3'h2, 30);
    rdchk(8'h28, 32'h0a);
    closed_loop <= 1'b1;
    target <= 16'h0bb8;
    pid_fb <= REF - 16'h32;
    repeat (30) @(posedge sys_clk);
    check(32'(state), 32'h2);
    pid_fb <= REF - 16'h33;
    wait_wake(1'b1);
    pid_fb <= REF;
  endtask

  // deviation sleep for both pid actions
  task automatic t_dev;
    wr(8'h04, 32'h2);
    for (int n = 0; n < 2; n++) begin
      pid_neg <= n[0];
      closed_loop <= ~n[0];
      pid_fb <= n[0] ? REF - 16'h32 : REF + 16'h32;
      repeat (30) @(posedge sys_clk);
      check(32'(state), 32'h0);
      pid_fb <= n[0] ? REF - 16'h33 : REF + 16'h33;
      wait_for(3'h1, 10);
      wait_for(3'h2, 60);
      pid_fb <= n[0] ? REF + 16'h33 : REF - 16'h33;
      wait_wake(~n[0]);
    end
    pid_neg <= 1'b0;
    pid_fb <= REF;
  endtask

  // sleep forced at upper limit, then disable
  task automatic t_upper;
    target <= 16'h1388;
    repeat (100) @(posedge sys_clk);
    pid_fb <= REF + 16'h33;
    wait_for(3'h2, 80);
    rdchk(8'h28, 32'h2a);
    wr(8'h00, 32'h0);
    wait_for(3'h0, 3);
    pid_fb <= REF;
    target <= 16'h0bb8;
  endtask

  // terminal method and the unused code
  task automatic t_term;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    closed_loop <= 1'b1;
    term <= 1'b1;
    wait_for(3'h2, 6);
    term <= 1'b0;
    wait_wake(1'b1);
    wr(8'h04, 32'h3);
    term <= 1'b1;
    pid_fb <= REF + 16'h33;
    repeat (40) @(posedge sys_clk);
    check(32'(state), 32'h0);
  endtask

  // counts, verdict, end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    target = 16'h0;
    pid_ref = REF;
    pid_fb = REF;
    pid_neg = 1'b0;
    closed_loop = 1'b0;
    term = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_defaults();
    t_freq();
    t_dev();
    t_upper();
    t_term();
    report_and_stop();
  end
endmodule
